// >>> table_read_xor_move_exec_tb_top.sv
module table_read_xor_move_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [10:0] rom_addr;
  logic [13:0] rom_data = 14'h0000;
  logic [32:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h4a7e_9e52;
  logic [7:0] accum_m, t0_m, fv, iv;
  logic [6:0] idx;
  logic [31:0] pw;
  logic [13:0] w14;
  logic z_m = 1'b0;

  trx_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data));

  always #10 pclk = ~pclk;

  function automatic logic [13:0] rom_fn(input logic [10:0] a);
    return {a[10:5] ^ 6'h2b, a[7:0] ^ 8'hc3};
  endfunction

  // synchronous program memory: answers one edge after the address moves
  always @(posedge pclk) rom_data <= rom_fn(rom_addr);

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // the expectation is queued before the request so the monitor always finds it
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    exp_q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a stuck slave is caught by the watchdog, which counts it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000, {25'h000_0000, e});
  endtask

  task automatic cmd(input logic [2:0] op, input logic dst, input logic [6:0] fa,
                     input logic [7:0] im);
    wr(trx_pkg::CMD_OFF, {8'h00, im, 1'b0, fa, 4'h0, dst, op});
  endtask

  function automatic logic [9:0] faddr(input logic [6:0] i);
    return {1'b1, i, 2'b00};
  endfunction

  // write data is don't-care in the compare, only the error flag counts
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
      chk({pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_q.pop_front());

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) rd(10'(4 * i), 8'h00);
    apb(1'b0, 10'h018, 32'h0000_0000, {1'b1, 32'h0000_0000});
    apb(1'b1, 10'h1fc, 32'hffff_ffff, {1'b1, 32'h0000_0000});
    for (int i = 0; i < 8; i++) begin
      accum_m = 8'($random(seed));
      idx = i == 0 ? 7'h00 : i == 1 ? 7'h7f : 7'($random(seed));
      fv = i == 2 ? accum_m : 8'($random(seed));
      iv = 8'($random(seed));
      wr(trx_pkg::ACCUM_OFF, {24'h00_0000, accum_m});
      wr(faddr(idx), {24'h00_0000, fv});
      cmd(3'h3, i[0], idx, 8'h00);
      if (i[0]) fv = fv ^ accum_m;
      else accum_m = accum_m ^ fv;
      z_m = (i[0] ? fv : accum_m) == 8'h00;
      rd(faddr(idx), fv);
      rd(trx_pkg::ACCUM_OFF, accum_m);
      rd(trx_pkg::STAT_OFF, {7'h00, z_m});
      if (i == 3) iv = accum_m;
      cmd(3'h4, 1'b0, 7'h00, iv);
      accum_m = accum_m ^ iv;
      z_m = accum_m == 8'h00;
      rd(trx_pkg::ACCUM_OFF, accum_m);
      rd(trx_pkg::STAT_OFF, {7'h00, z_m});
    end
    // force the zero flag high so that a flag change by table or move shows
    cmd(3'h4, 1'b0, 7'h00, accum_m);
    accum_m = 8'h00;
    z_m = 1'b1;
    for (int j = 0; j < 3; j++) begin
      pw = $random(seed);
      wr(trx_pkg::PTR_HIGH_OFF, pw);
      rd(trx_pkg::PTR_HIGH_OFF, {5'h00, pw[2:0]});
      accum_m = 8'($random(seed));
      wr(trx_pkg::ACCUM_OFF, {24'h00_0000, accum_m});
      cmd(3'h1, 1'b0, 7'h00, 8'h00);
      chk(33'(rom_addr), 33'({pw[2:0], accum_m}));
      w14 = rom_fn({pw[2:0], accum_m});
      accum_m = w14[7:0];
      rd(trx_pkg::ACCUM_OFF, accum_m);
      rd(trx_pkg::DATA_HIGH_OFF, {2'b00, w14[13:8]});
      rd(trx_pkg::STAT_OFF, {7'h00, z_m});
      t0_m = 8'($random(seed)) | 8'h01;
      wr(trx_pkg::TMODE_OFF, {24'h00_0000, t0_m});
      cmd(3'h2, 1'b0, 7'h00, 8'h00);
      accum_m = t0_m;
      rd(trx_pkg::ACCUM_OFF, accum_m);
      rd(trx_pkg::STAT_OFF, {7'h00, z_m});
    end
    for (int k = 0; k < 4; k++) begin
      cmd(k == 0 ? 3'h0 : 3'(k + 4), 1'b1, 7'h00, 8'($random(seed)));
      rd(trx_pkg::ACCUM_OFF, accum_m);
    end
    repeat (4) @(posedge pclk);
    chk(33'(exp_q.size()), 33'h0_0000_0000);
    print_verdict();
  end
endmodule

// >>> trx_exec.sv
module trx_exec (
  input wire logic pclk, // clock, 50 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [trx_pkg::PADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic [trx_pkg::ROM_AW-1:0] rom_addr, // program memory address
  input wire logic [trx_pkg::ROM_W-1:0] rom_data // program word, synchronous
);
  typedef enum logic {ST_IDLE, ST_EXEC} trx_state_e;

  function automatic logic is_mapped(input logic [trx_pkg::PADDR_W-1:0] a);
    is_mapped = a[trx_pkg::FILE_SEL_BIT] || a == trx_pkg::ACCUM_OFF
      || a == trx_pkg::PTR_HIGH_OFF || a == trx_pkg::DATA_HIGH_OFF || a == trx_pkg::TMODE_OFF
      || a == trx_pkg::STAT_OFF || a == trx_pkg::CMD_OFF;
  endfunction

  trx_state_e state_r, state_nxt;
  logic [trx_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  trx_pkg::trx_cmd_s cmd_r, cmd_nxt;
  logic [trx_pkg::DATA_W-1:0] accum_r, accum_nxt, tmode_r, tmode_nxt;
  logic [trx_pkg::PTR_W-1:0] ptr_high_r, ptr_high_nxt;
  logic [trx_pkg::DATA_HIGH_W-1:0] data_high_r, data_high_nxt;
  logic zero_r, zero_nxt;
  logic [trx_pkg::ROM_AW-1:0] rom_addr_r, rom_addr_nxt;
  logic done_r, done_nxt, idle_prev_r;
  logic [31:0] prdata_r, prdata_nxt;
  logic mem_we;
  logic [trx_pkg::FADDR_W-1:0] mem_waddr, mem_raddr, apb_idx;
  logic [trx_pkg::DATA_W-1:0] mem_wdata, mem_rdata, xor_res;
  logic busy, commit, wr_fire;
  trx_pkg::trx_cmd_s new_cmd;

  assign busy = state_r == ST_EXEC;
  assign commit = busy && cnt_r == trx_pkg::CNT_ZERO;
  assign apb_idx = paddr[trx_pkg::WORD_LSB +: trx_pkg::FADDR_W];
  // every access waits at least one cycle so that read data always comes from a flop
  assign pready = psel && penable && done_r;
  assign pslverr = pready && !is_mapped(paddr);
  assign wr_fire = pready && pwrite && is_mapped(paddr);
  assign prdata = prdata_r;
  assign rom_addr = rom_addr_r;
  assign new_cmd = '{op: trx_pkg::trx_op_e'(pwdata[trx_pkg::CMD_OP_LSB +: trx_pkg::OP_W]),
                     dest: pwdata[trx_pkg::CMD_DEST_BIT],
                     faddr: pwdata[trx_pkg::CMD_FADDR_LSB +: trx_pkg::FADDR_W],
                     imm: pwdata[trx_pkg::CMD_IMM_LSB +: trx_pkg::DATA_W]};
  assign xor_res = accum_r ^ (cmd_r.op == trx_pkg::OP_XOR_FILE ? mem_rdata : cmd_r.imm);

  // the engine owns the read port while busy; bus reads of the file wait it out
  assign mem_raddr = busy ? cmd_r.faddr : apb_idx;

  trx_file_mem u_file (
    .pclk(pclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    accum_nxt = accum_r;
    tmode_nxt = tmode_r;
    ptr_high_nxt = ptr_high_r;
    data_high_nxt = data_high_r;
    zero_nxt = zero_r;
    rom_addr_nxt = rom_addr_r;
    mem_we = 1'b0;
    mem_waddr = apb_idx;
    mem_wdata = pwdata[trx_pkg::DATA_W-1:0];
    case (state_r)
      ST_IDLE: begin
        if (wr_fire) begin
          if (paddr[trx_pkg::FILE_SEL_BIT]) begin
            mem_we = 1'b1;
          end else if (paddr == trx_pkg::ACCUM_OFF) begin
            accum_nxt = pwdata[trx_pkg::DATA_W-1:0];
          end else if (paddr == trx_pkg::PTR_HIGH_OFF) begin
            ptr_high_nxt = pwdata[trx_pkg::PTR_W-1:0];
          end else if (paddr == trx_pkg::TMODE_OFF) begin
            tmode_nxt = pwdata[trx_pkg::DATA_W-1:0];
          end else if (paddr == trx_pkg::CMD_OFF && new_cmd.op != trx_pkg::OP_NOP) begin
            state_nxt = ST_EXEC;
            cmd_nxt = new_cmd;
            cnt_nxt = new_cmd.op == trx_pkg::OP_TABLE ?
              trx_pkg::TABLE_LAST : trx_pkg::ONE_LAST;
            rom_addr_nxt = {ptr_high_r, accum_r};
          end
        end
      end
      ST_EXEC: begin
        if (!commit) begin
          cnt_nxt = cnt_r - trx_pkg::CNT_STEP;
        end else begin
          state_nxt = ST_IDLE;
          case (cmd_r.op)
            trx_pkg::OP_TABLE: begin
              accum_nxt = rom_data[trx_pkg::ROM_LO_MSB:0];
              data_high_nxt = rom_data[trx_pkg::ROM_HI_MSB:trx_pkg::ROM_HI_LSB];
            end
            trx_pkg::OP_MOVE_MODE: begin
              accum_nxt = tmode_r;
            end
            trx_pkg::OP_XOR_FILE: begin
              zero_nxt = xor_res == trx_pkg::ZERO_BYTE;
              if (cmd_r.dest) begin
                mem_we = 1'b1;
                mem_waddr = cmd_r.faddr;
                mem_wdata = xor_res;
              end else begin
                accum_nxt = xor_res;
              end
            end
            trx_pkg::OP_XOR_IMM: begin
              accum_nxt = xor_res;
              zero_nxt = xor_res == trx_pkg::ZERO_BYTE;
            end
            default: begin
              accum_nxt = accum_r;
            end
          endcase
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= trx_pkg::CNT_ZERO;
      cmd_r <= trx_pkg::CMD_RST;
      accum_r <= trx_pkg::ACCUM_RST;
      tmode_r <= trx_pkg::TMODE_RST;
      ptr_high_r <= trx_pkg::PTR_HIGH_RST;
      data_high_r <= trx_pkg::DATA_HIGH_RST;
      zero_r <= 1'b0;
      rom_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
      accum_r <= accum_nxt;
      tmode_r <= tmode_nxt;
      ptr_high_r <= ptr_high_nxt;
      data_high_r <= data_high_nxt;
      zero_r <= zero_nxt;
      rom_addr_r <= rom_addr_nxt;
    end
  end

  // capture only after a full idle cycle, so the file read port saw the bus index
  always_comb begin
    done_nxt = done_r;
    prdata_nxt = prdata_r;
    if (pready) begin
      done_nxt = 1'b0;
    end else if (psel && penable && !busy && idle_prev_r) begin
      done_nxt = 1'b1;
      if (paddr[trx_pkg::FILE_SEL_BIT]) begin
        prdata_nxt = 32'(mem_rdata);
      end else if (paddr == trx_pkg::ACCUM_OFF) begin
        prdata_nxt = 32'(accum_r);
      end else if (paddr == trx_pkg::PTR_HIGH_OFF) begin
        prdata_nxt = 32'(ptr_high_r);
      end else if (paddr == trx_pkg::DATA_HIGH_OFF) begin
        prdata_nxt = 32'(data_high_r);
      end else if (paddr == trx_pkg::TMODE_OFF) begin
        prdata_nxt = 32'(tmode_r);
      end else if (paddr == trx_pkg::STAT_OFF) begin
        prdata_nxt = 32'({busy, zero_r});
      end else begin
        prdata_nxt = trx_pkg::RDATA_RST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      prdata_r <= trx_pkg::RDATA_RST;
      idle_prev_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      prdata_r <= prdata_nxt;
      idle_prev_r <= !busy;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  table_len_a: assert property (
    $rose(busy) && cmd_r.op == trx_pkg::OP_TABLE |-> busy[*4] ##1 !busy)
    else $error("table read did not take two instruction cycles");
  table_addr_a: assert property (
    busy && cmd_r.op == trx_pkg::OP_TABLE |-> rom_addr == {ptr_high_r, accum_r})
    else $error("table read address not pointer high over accumulator");
  table_low_a: assert property (
    commit && cmd_r.op == trx_pkg::OP_TABLE |=>
      accum_r == $past(rom_data[trx_pkg::ROM_LO_MSB:0]) && $stable(zero_r))
    else $error("table read low byte or flag wrong");
  table_high_a: assert property (
    commit && cmd_r.op == trx_pkg::OP_TABLE |=>
      data_high_r == $past(rom_data[trx_pkg::ROM_HI_MSB:trx_pkg::ROM_HI_LSB]))
    else $error("table read high bits wrong");
  move_mode_a: assert property (
    commit && cmd_r.op == trx_pkg::OP_MOVE_MODE |=>
      accum_r == $past(tmode_r) && $stable(zero_r))
    else $error("timer mode move wrong");
  xor_len_a: assert property (
    $rose(busy) && cmd_r.op != trx_pkg::OP_TABLE |-> busy[*2] ##1 !busy)
    else $error("one-cycle instruction took wrong time");
  // a file write-back must land on the commanded index with the combined byte
  xor_dest_a: assert property (
    commit && cmd_r.op == trx_pkg::OP_XOR_FILE |->
      mem_we == cmd_r.dest
      && (!cmd_r.dest || (mem_waddr == cmd_r.faddr && mem_wdata == (accum_r ^ mem_rdata)))
      ##1 accum_r == ($past(cmd_r.dest) ? $past(accum_r) : $past(accum_r ^ mem_rdata)))
    else $error("file exclusive-OR destination wrong");
  xor_imm_a: assert property (
    commit && cmd_r.op == trx_pkg::OP_XOR_IMM |=> accum_r == $past(accum_r ^ cmd_r.imm))
    else $error("immediate exclusive-OR wrong");
  zero_flag_a: assert property (
    commit && (cmd_r.op == trx_pkg::OP_XOR_FILE || cmd_r.op == trx_pkg::OP_XOR_IMM) |=>
      zero_r == ($past(xor_res) == trx_pkg::ZERO_BYTE))
    else $error("zero flag wrong");

  table_run_c: cover property (commit && cmd_r.op == trx_pkg::OP_TABLE);
  move_run_c: cover property (commit && cmd_r.op == trx_pkg::OP_MOVE_MODE);
  xor_file_c: cover property (commit && cmd_r.op == trx_pkg::OP_XOR_FILE && cmd_r.dest);
  xor_zero_c: cover property (
    commit && cmd_r.op == trx_pkg::OP_XOR_IMM && xor_res == trx_pkg::ZERO_BYTE);
endmodule

// >>> trx_file_mem.sv
module trx_file_mem (
  input wire logic pclk, // clock
  input wire logic we, // write strobe
  input wire logic [trx_pkg::FADDR_W-1:0] waddr, // write index
  input wire logic [trx_pkg::DATA_W-1:0] wdata, // write byte
  input wire logic [trx_pkg::FADDR_W-1:0] raddr, // read index
  output logic [trx_pkg::DATA_W-1:0] rdata // registered read byte
);
  logic [trx_pkg::DATA_W-1:0] mem_r [trx_pkg::FILE_DEPTH];

  // no reset: file registers hold no defined value until written
  always_ff @(posedge pclk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end
endmodule

// >>> trx_pkg.sv
package trx_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ROM_W = 14;
  localparam int unsigned ROM_AW = 11;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned DATA_HIGH_W = 6;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned PADDR_W = 10;
  localparam int unsigned CNT_W = 3;

  localparam logic [PADDR_W-1:0] ACCUM_OFF = 10'h000;
  localparam logic [PADDR_W-1:0] PTR_HIGH_OFF = 10'h004;
  localparam logic [PADDR_W-1:0] DATA_HIGH_OFF = 10'h008;
  localparam logic [PADDR_W-1:0] TMODE_OFF = 10'h00C;
  localparam logic [PADDR_W-1:0] STAT_OFF = 10'h010;
  localparam logic [PADDR_W-1:0] CMD_OFF = 10'h014;
  localparam int unsigned FILE_SEL_BIT = 9;
  localparam int unsigned WORD_LSB = 2;

  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned OP_W = 3;
  localparam int unsigned CMD_DEST_BIT = 3;
  localparam int unsigned CMD_FADDR_LSB = 8;
  localparam int unsigned CMD_IMM_LSB = 16;
  localparam int unsigned STAT_ZERO_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;

  localparam int unsigned ROM_LO_MSB = 7;
  localparam int unsigned ROM_HI_LSB = 8;
  localparam int unsigned ROM_HI_MSB = 13;

  // one instruction cycle spans two pclk: operand fetch, then execute
  localparam int unsigned INST_PCLKS = 2;
  localparam int unsigned ONE_INST = 1;
  localparam int unsigned TABLE_INST = 2;
  localparam logic [CNT_W-1:0] ONE_LAST = CNT_W'(ONE_INST * INST_PCLKS - 1);
  localparam logic [CNT_W-1:0] TABLE_LAST = CNT_W'(TABLE_INST * INST_PCLKS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;

  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [DATA_W-1:0] TMODE_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_HIGH_RST = 3'h0;
  localparam logic [DATA_HIGH_W-1:0] DATA_HIGH_RST = 6'h00;
  // value an exclusive-OR result is compared with for the zero flag
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [OP_W-1:0] {
    OP_NOP,
    OP_TABLE,
    OP_MOVE_MODE,
    OP_XOR_FILE,
    OP_XOR_IMM
  } trx_op_e;

  typedef struct packed {
    trx_op_e op;
    logic dest;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] imm;
  } trx_cmd_s;

  localparam trx_cmd_s CMD_RST = '{op: OP_NOP, dest: 1'b0, faddr: 7'h00, imm: 8'h00};
endpackage
